// ---- rtl/timer_ext_pkg.sv ----
// Shared constants for the timer extension block
package timer_ext_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TL = 8'hfb;
    localparam logic [7:0] IDX_TH = 8'hfc;
    localparam logic [7:0] IDX_CM = 8'hfd;
    localparam logic [7:0] IDX_COR = 8'he0;
    localparam logic [7:0] IDX_D13 = 8'he1;
    localparam logic [7:0] IDX_PMR = 8'he2;
    localparam logic [7:0] IDX_IEX = 8'he3;
    localparam logic [7:0] IDX_TA = 8'he4;
    localparam int ADDR_W = 10;
    localparam int IDX_LSB = 2;

    // Control/mode register fields
    localparam int CM_TF = 7;
    localparam int CM_TR = 6;
    localparam int CM_T3M = 5;
    localparam int CM_SMOD = 4;
    localparam int CM_GATE = 3;
    localparam int CM_CT = 2;
    localparam int CM_MODE_HI = 1;
    localparam int CM_MODE_LO = 0;

    // Clock output register fields
    localparam int COR_IR16 = 7;
    localparam int COR_DIV_HI = 2;
    localparam int COR_DIV_LO = 1;
    localparam int COR_OE = 0;

    // Divide-by-13, clock multiplier and interrupt enable fields
    localparam int D13_T1 = 0;
    localparam int D13_T2 = 1;
    localparam int PMR_CD_HI = 1;
    localparam int PMR_CD_LO = 0;
    localparam int PMR_X4 = 2;
    localparam int IEX_ET3 = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Timed-access unlock
    localparam logic [7:0] TA_KEY1 = 8'haa;
    localparam logic [7:0] TA_KEY2 = 8'h55;
    localparam logic [2:0] TA_OPEN_CYC = 3'h4;

    // Timer time base periods in system clocks
    localparam int PRE_W = 12;
    localparam logic [11:0] PRE_T12 = 12'h00c;
    localparam logic [11:0] PRE_T12_X2 = 12'h006;
    localparam logic [11:0] PRE_T12_X4 = 12'h003;
    localparam logic [11:0] PRE_T12_PMM = 12'hc00;
    localparam logic [11:0] PRE_T4 = 12'h004;
    localparam logic [11:0] PRE_T4_X2 = 12'h002;
    localparam logic [11:0] PRE_T4_X4 = 12'h001;
    localparam logic [11:0] PRE_T4_PMM = 12'h400;
    localparam logic [1:0] CD_MULT = 2'h0;
    localparam logic [1:0] CD_PMM = 2'h3;

    localparam int DIV13_PERIOD = 13;
    localparam logic [1:0] SER_MODE1 = 2'h1;
    localparam logic [1:0] SER_MODE3 = 2'h3;
    localparam logic [7:0] T3_VECTOR = 8'h4b;
    localparam logic [3:0] T3_PRIORITY = 4'h9;

    typedef enum logic [1:0] {MODE_13, MODE_16, MODE_8AR, MODE_HOLD} mode_t;
    typedef enum logic [1:0] {TA_IDLE, TA_ARMED, TA_OPEN} ta_t;
endpackage

// ---- rtl/tick_div.sv ----
// Free-running modulo-N divider giving a one-cycle tick
`timescale 1ns/100ps
module tick_div #(
    parameter int PERIOD = 13
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    output logic tick_o
);
    localparam int W = $clog2(PERIOD);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);
    localparam logic [W-1:0] ONE = W'(1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + ONE;
        end
    end
endmodule

// ---- rtl/timer_ext.sv ----
// Fourth timer, divide-by-13 time base and clock output, APB slave
//
// Behaviour
// - Fourth timer runs 13-bit, 16-bit or 8-bit auto-reload.
// - Its overflow feeds serial port 2 baud timing in modes 1, 3.
// - Control bit 3 gates by interrupt 3, bit 2 counter/timer, 1:0 mode.
// - Control bit 7 overflow flag, bit 6 run, bit 5 divide-by-4 clock.
// - Count low byte at FBh, high byte at FCh.
// - No second power divide; multiplier bits set timer time base.
// - Timers 1 and 2 have independent divide-by-13 enables.
// - With enable set, timer counts system clock over 13, not pin.
// - Applies to all modes except timer 2 baud-rate generator mode.
// - Enabled clock output is a 50% duty square wave on the pin.
// - Output runs freely from system clock, unsynchronised.
// - Clock output bits 2:1 pick system clock over 2, 4, 6, 8.
// - Bit 0 enables output; appears only while port latch is 1.
// - Bits 7 and 0 set: pin carries 16x serial 0 baud clock.
// - Interrupt vector 4Bh, priority 9, enable in bit 1.
// - Control bit 4 doubles serial port 2 baud rate.
`timescale 1ns/100ps
module timer_ext (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [timer_ext_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic external_interrupt_three_i,
    input wire logic timer_three_pin_i,
    input wire logic timer_one_pin_i,
    input wire logic timer_two_pin_i,
    input wire logic timer_two_baud_mode_i,
    input wire logic [1:0] serial_two_mode_i,
    input wire logic serial_zero_x32_tick_i,
    input wire logic clock_output_port_latch_i,
    input wire logic timer_three_int_ack_i,
    output logic timer_one_count_tick_o,
    output logic timer_two_count_tick_o,
    output logic serial_two_baud_tick_o,
    output logic serial_two_baud_doubler_o,
    output logic timer_three_irq_o,
    output logic [7:0] timer_three_vector_o,
    output logic [3:0] timer_three_priority_o,
    output logic clock_output_port_pin_o
);
    logic [7:0] tl_q;
    logic [7:0] th_q;
    logic [7:0] cm_q;
    logic [7:0] cor_q;
    logic [7:0] d13_q;
    logic [7:0] pmr_q;
    logic [7:0] iex_q;
    logic [7:0] tl_d;
    logic [7:0] th_d;
    logic ovf;
    logic [7:0] idx;
    logic setup;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] rd_data;
    logic rd_hit;
    timer_ext_pkg::ta_t ta_q;
    logic [2:0] ta_cnt_q;
    logic [timer_ext_pkg::PRE_W-1:0] pre_q;
    logic [timer_ext_pkg::PRE_W-1:0] pre_period;
    logic pre_tick;
    logic t3_prev_q;
    logic t1_prev_q;
    logic t2_prev_q;
    logic inc;
    timer_ext_pkg::mode_t mode;
    logic div13_tick;
    logic [1:0] co_cnt_q;
    logic wave_q;

    assign idx = paddr_i[timer_ext_pkg::ADDR_W-1:timer_ext_pkg::IDX_LSB];
    assign setup = psel_i & penable_i & ~pready_o;
    assign wr = psel_i & penable_i & pready_o & pwrite_i;
    assign wbyte = pwdata_i[7:0];
    assign mode = timer_ext_pkg::mode_t'(
        cm_q[timer_ext_pkg::CM_MODE_HI:timer_ext_pkg::CM_MODE_LO]);

    // One wait state: answer registered so outputs stay flop-driven
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_o <= 1'b0;
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o <= setup;
            // Error stands only with its answer
            pslverr_o <= setup & ~rd_hit;
            if (setup)
            begin
                prdata_o <= {24'h000000, rd_data};
            end
        end
    end

    always_comb
    begin
        rd_hit = 1'b1;
        rd_data = 8'h00;
        unique case (idx)
            timer_ext_pkg::IDX_TL: rd_data = tl_q;
            timer_ext_pkg::IDX_TH: rd_data = th_q;
            timer_ext_pkg::IDX_CM: rd_data = cm_q;
            timer_ext_pkg::IDX_COR: rd_data = cor_q;
            timer_ext_pkg::IDX_D13: rd_data = d13_q;
            timer_ext_pkg::IDX_PMR: rd_data = pmr_q;
            timer_ext_pkg::IDX_IEX: rd_data = iex_q;
            timer_ext_pkg::IDX_TA: rd_data = 8'h00;
            default: rd_hit = 1'b0;
        endcase
    end

    // Timed access: key pair opens a short window for the clock output
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ta_q <= timer_ext_pkg::TA_IDLE;
            ta_cnt_q <= 3'h0;
        end
        else if (wr && idx == timer_ext_pkg::IDX_TA)
        begin
            if (wbyte == timer_ext_pkg::TA_KEY1)
                ta_q <= timer_ext_pkg::TA_ARMED;
            else if (wbyte == timer_ext_pkg::TA_KEY2 &&
                     ta_q == timer_ext_pkg::TA_ARMED)
            begin
                ta_q <= timer_ext_pkg::TA_OPEN;
                ta_cnt_q <= timer_ext_pkg::TA_OPEN_CYC;
            end
            else
                ta_q <= timer_ext_pkg::TA_IDLE;
        end
        else if (ta_q == timer_ext_pkg::TA_OPEN)
        begin
            // Window also closes after one protected write
            if (ta_cnt_q == 3'h0 || (wr && idx == timer_ext_pkg::IDX_COR))
                ta_q <= timer_ext_pkg::TA_IDLE;
            else
                ta_cnt_q <= ta_cnt_q - 3'h1;
        end
    end

    // Plain configuration registers
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            d13_q <= timer_ext_pkg::RESET_BYTE;
            pmr_q <= timer_ext_pkg::RESET_BYTE;
            iex_q <= timer_ext_pkg::RESET_BYTE;
        end
        else if (wr)
        begin
            if (idx == timer_ext_pkg::IDX_D13)
                d13_q <= wbyte;
            if (idx == timer_ext_pkg::IDX_PMR)
                pmr_q <= wbyte;
            if (idx == timer_ext_pkg::IDX_IEX)
                iex_q <= wbyte;
        end
    end

    // Clock output register; unlocked writes are dropped silently
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cor_q <= timer_ext_pkg::RESET_BYTE;
        else if (wr && idx == timer_ext_pkg::IDX_COR &&
                 ta_q == timer_ext_pkg::TA_OPEN)
            cor_q <= wbyte;
    end

    // Time base from multiplier bits; no second power divide exists
    always_comb
    begin
        pre_period = timer_ext_pkg::PRE_T12;
        unique case (pmr_q[timer_ext_pkg::PMR_CD_HI:timer_ext_pkg::PMR_CD_LO])
            timer_ext_pkg::CD_MULT:
                if (pmr_q[timer_ext_pkg::PMR_X4])
                    pre_period = cm_q[timer_ext_pkg::CM_T3M] ?
                        timer_ext_pkg::PRE_T4_X4 : timer_ext_pkg::PRE_T12_X4;
                else
                    pre_period = cm_q[timer_ext_pkg::CM_T3M] ?
                        timer_ext_pkg::PRE_T4_X2 : timer_ext_pkg::PRE_T12_X2;
            timer_ext_pkg::CD_PMM:
                pre_period = cm_q[timer_ext_pkg::CM_T3M] ?
                    timer_ext_pkg::PRE_T4_PMM : timer_ext_pkg::PRE_T12_PMM;
            default:
                pre_period = cm_q[timer_ext_pkg::CM_T3M] ?
                    timer_ext_pkg::PRE_T4 : timer_ext_pkg::PRE_T12;
        endcase
    end

    assign pre_tick = (pre_q >= pre_period - 12'h001);

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pre_q <= '0;
        else if (pre_tick)
            pre_q <= '0;
        else
            pre_q <= pre_q + 12'h001;
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            t3_prev_q <= 1'b0;
            t1_prev_q <= 1'b0;
            t2_prev_q <= 1'b0;
        end
        else
        begin
            t3_prev_q <= timer_three_pin_i;
            t1_prev_q <= timer_one_pin_i;
            t2_prev_q <= timer_two_pin_i;
        end
    end

    // Count on falling pin edge or time base, gated by run and gate
    assign inc = cm_q[timer_ext_pkg::CM_TR] &
        (~cm_q[timer_ext_pkg::CM_GATE] | external_interrupt_three_i) &
        (cm_q[timer_ext_pkg::CM_CT] ? (t3_prev_q & ~timer_three_pin_i)
                                    : pre_tick);

    always_comb
    begin
        tl_d = tl_q;
        th_d = th_q;
        ovf = 1'b0;
        if (inc)
        begin
            unique case (mode)
                timer_ext_pkg::MODE_13:
                begin
                    tl_d[4:0] = tl_q[4:0] + 5'h01;
                    if (tl_q[4:0] == 5'h1f)
                        th_d = th_q + 8'h01;
                    ovf = (tl_q[4:0] == 5'h1f) && (th_q == 8'hff);
                end
                timer_ext_pkg::MODE_16:
                begin
                    tl_d = tl_q + 8'h01;
                    if (tl_q == 8'hff)
                        th_d = th_q + 8'h01;
                    ovf = (tl_q == 8'hff) && (th_q == 8'hff);
                end
                timer_ext_pkg::MODE_8AR:
                begin
                    tl_d = (tl_q == 8'hff) ? th_q : tl_q + 8'h01;
                    ovf = (tl_q == 8'hff);
                end
                timer_ext_pkg::MODE_HOLD:
                begin
                    // Split mode is not offered: counter holds
                    tl_d = tl_q;
                end
            endcase
        end
    end

    // Software writes win over a count in the same cycle
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tl_q <= timer_ext_pkg::RESET_BYTE;
            th_q <= timer_ext_pkg::RESET_BYTE;
        end
        else
        begin
            tl_q <= (wr && idx == timer_ext_pkg::IDX_TL) ? wbyte : tl_d;
            th_q <= (wr && idx == timer_ext_pkg::IDX_TH) ? wbyte : th_d;
        end
    end

    // Overflow flag: a set in the clearing cycle is kept
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            cm_q <= timer_ext_pkg::RESET_BYTE;
        else
        begin
            if (wr && idx == timer_ext_pkg::IDX_CM)
                cm_q[6:0] <= wbyte[6:0];
            if (ovf)
                cm_q[timer_ext_pkg::CM_TF] <= 1'b1;
            else if (wr && idx == timer_ext_pkg::IDX_CM)
                cm_q[timer_ext_pkg::CM_TF] <= wbyte[timer_ext_pkg::CM_TF];
            else if (timer_three_int_ack_i)
                cm_q[timer_ext_pkg::CM_TF] <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            timer_three_irq_o <= 1'b0;
            timer_three_vector_o <= timer_ext_pkg::T3_VECTOR;
            timer_three_priority_o <= timer_ext_pkg::T3_PRIORITY;
            serial_two_baud_tick_o <= 1'b0;
            serial_two_baud_doubler_o <= 1'b0;
        end
        else
        begin
            timer_three_irq_o <= cm_q[timer_ext_pkg::CM_TF] &
                iex_q[timer_ext_pkg::IEX_ET3];
            timer_three_vector_o <= timer_ext_pkg::T3_VECTOR;
            timer_three_priority_o <= timer_ext_pkg::T3_PRIORITY;
            serial_two_baud_tick_o <= ovf &
                (serial_two_mode_i == timer_ext_pkg::SER_MODE1 ||
                 serial_two_mode_i == timer_ext_pkg::SER_MODE3);
            serial_two_baud_doubler_o <=
                cm_q[timer_ext_pkg::CM_SMOD];
        end
    end

    tick_div #(
        .PERIOD(timer_ext_pkg::DIV13_PERIOD)
    ) u_div13 (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .tick_o(div13_tick)
    );

    // Timer 2 baud generator keeps its pin, whatever the enable says
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            timer_one_count_tick_o <= 1'b0;
            timer_two_count_tick_o <= 1'b0;
        end
        else
        begin
            timer_one_count_tick_o <= d13_q[timer_ext_pkg::D13_T1] ?
                div13_tick : (t1_prev_q & ~timer_one_pin_i);
            timer_two_count_tick_o <=
                (d13_q[timer_ext_pkg::D13_T2] && !timer_two_baud_mode_i) ?
                div13_tick : (t2_prev_q & ~timer_two_pin_i);
        end
    end

    // Half period is divide field plus one clock
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            co_cnt_q <= 2'h0;
            wave_q <= 1'b0;
        end
        else if (!cor_q[timer_ext_pkg::COR_OE])
        begin
            co_cnt_q <= 2'h0;
            wave_q <= 1'b0;
        end
        else if (cor_q[timer_ext_pkg::COR_IR16])
        begin
            if (serial_zero_x32_tick_i)
                wave_q <= ~wave_q;
        end
        else if (co_cnt_q ==
                 cor_q[timer_ext_pkg::COR_DIV_HI:timer_ext_pkg::COR_DIV_LO])
        begin
            co_cnt_q <= 2'h0;
            wave_q <= ~wave_q;
        end
        else
            co_cnt_q <= co_cnt_q + 2'h1;
    end

    // Pin follows the latch unless output enabled and latch is one
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            clock_output_port_pin_o <= 1'b0;
        else
            clock_output_port_pin_o <= clock_output_port_latch_i &
                (~cor_q[timer_ext_pkg::COR_OE] | wave_q);
    end
endmodule

// ---- testbench/timer_ext_assertions.sv ----
// Port checks for the timer extension block
`timescale 1ns/100ps
module timer_ext_assertions (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire logic [1:0] serial_two_mode_i,
    input wire logic clock_output_port_latch_i,
    input wire logic timer_one_count_tick_o,
    input wire logic timer_two_count_tick_o,
    input wire logic serial_two_baud_tick_o,
    input wire logic [7:0] timer_three_vector_o,
    input wire logic [3:0] timer_three_priority_o,
    input wire logic clock_output_port_pin_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);
    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_answer;
        pready_o ##1 !pready_o;
    endsequence
    a_one_wait: assert property (s_access |=> s_answer)
        else $error("bus answer not one cycle after access");
    a_ready_cause: assert property (pready_o |-> $past(penable_i))
        else $error("answer without a request");
    a_err_data: assert property (
        pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error answer malformed");
    a_upper_zero: assert property (
        pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_vector_fixed: assert property (timer_three_vector_o == 8'h4b)
        else $error("vector wrong");
    a_prio_fixed: assert property (timer_three_priority_o == 4'h9)
        else $error("priority wrong");
    a_baud_mode: assert property (
        serial_two_baud_tick_o |-> $past(serial_two_mode_i[0]))
        else $error("baud tick outside modes 1 and 3");
    a_pin_latch: assert property (
        $past(!clock_output_port_latch_i) |-> !clock_output_port_pin_o)
        else $error("pin high with latch low");
    a_one_tick: assert property (
        timer_one_count_tick_o |=> !timer_one_count_tick_o)
        else $error("timer one tick too long");
    a_two_tick: assert property (
        timer_two_count_tick_o |=> !timer_two_count_tick_o)
        else $error("timer two tick too long");
endmodule

bind timer_ext timer_ext_assertions chk (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .serial_two_mode_i(serial_two_mode_i),
    .clock_output_port_latch_i(clock_output_port_latch_i),
    .timer_one_count_tick_o(timer_one_count_tick_o),
    .timer_two_count_tick_o(timer_two_count_tick_o),
    .serial_two_baud_tick_o(serial_two_baud_tick_o),
    .timer_three_vector_o(timer_three_vector_o),
    .timer_three_priority_o(timer_three_priority_o),
    .clock_output_port_pin_o(clock_output_port_pin_o)
);

// ---- testbench/x32_source.sv ----
// Serial port 0 side: 32x baud tick feeding the 16x clock output
`timescale 1ns/100ps
module x32_source #(
    parameter int PERIOD = 5
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    output logic tick_o
);
    int cnt;
    // Port is running before 16x select is made
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt <= 0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == PERIOD - 1 || !run_i) ? 0 : cnt + 1;
            tick_o <= run_i && cnt == PERIOD - 1;
        end
    end
endmodule

// ---- testbench/timer_ext_tb.sv ----
// Self-checking bench for the timer extension block
`timescale 1ns/100ps
module timer_ext_tb;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic external_interrupt_three = 1'b0, t3pin = 1'b1, t2baud = 1'b0;
    logic latch = 1'b0, ack = 1'b0, x32_en = 1'b0;
    logic [1:0] smode = 2'h0;
    logic pready, pslverr, x32, t1tick, t2tick, btick, dbl, irq, pin;
    logic [31:0] prdata;
    logic [7:0] vec, rd, cfg;
    logic [3:0] pri;
    logic err;
    int errors = 0;
    int check_count = 0;
    int hi, lo, n1, n2, nb, dv;
    always #5 mclk_i = ~mclk_i;
    x32_source #(.PERIOD(5)) u_src (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .run_i(x32_en), .tick_o(x32)
    );
    timer_ext DUT (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
        .pslverr_o(pslverr), .external_interrupt_three_i(external_interrupt_three),
        .timer_three_pin_i(t3pin), .timer_one_pin_i(1'b1),
        .timer_two_pin_i(1'b1), .timer_two_baud_mode_i(t2baud),
        .serial_two_mode_i(smode), .serial_zero_x32_tick_i(x32),
        .clock_output_port_latch_i(latch), .timer_three_int_ack_i(ack),
        .timer_one_count_tick_o(t1tick), .timer_two_count_tick_o(t2tick),
        .serial_two_baud_tick_o(btick), .serial_two_baud_doubler_o(dbl),
        .timer_three_irq_o(irq), .timer_three_vector_o(vec),
        .timer_three_priority_o(pri), .clock_output_port_pin_o(pin)
    );
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Called just after an edge; returns one edge after release
    task automatic apb(input logic wr, input logic [7:0] idx, wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            errors++;
            finish_test();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] idx, wd);
        apb(1'b1, idx, wd);
    endtask
    task automatic rdc(input string what, input logic [7:0] idx, exp);
        apb(1'b0, idx, 8'h00);
        check(what, rd, exp);
    endtask
    task automatic unlock();
        wr(timer_ext_pkg::IDX_TA, timer_ext_pkg::TA_KEY1);
        wr(timer_ext_pkg::IDX_TA, timer_ext_pkg::TA_KEY2);
    endtask
    task automatic pulses(input int n);
        repeat (n)
        begin
            t3pin <= 1'b0;
            repeat (3) @(posedge mclk_i);
            t3pin <= 1'b1;
            repeat (3) @(posedge mclk_i);
        end
    endtask
    task automatic count_ticks(input int len);
        n1 = 0;
        n2 = 0;
        nb = 0;
        repeat (len)
        begin
            @(posedge mclk_i);
            n1 += int'(t1tick === 1'b1);
            n2 += int'(t2tick === 1'b1);
            nb += int'(btick === 1'b1);
        end
    endtask
    // Bounded: a stuck pin ends the run
    task automatic wait_pin(input logic v, output int k);
        k = 0;
        while (pin !== v && k < 200)
        begin
            @(posedge mclk_i);
            k++;
        end
        if (pin !== v)
        begin
            errors++;
            finish_test();
        end
    endtask
    // Skips a partial phase left by a divider change
    task automatic halves();
        int k;
        wait_pin(1'b0, k);
        wait_pin(1'b1, k);
        wait_pin(1'b0, hi);
        wait_pin(1'b1, lo);
    endtask
    initial
    begin
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        @(posedge mclk_i);
        rdc("low reset", timer_ext_pkg::IDX_TL, 8'h00);
        rdc("mode reset", timer_ext_pkg::IDX_CM, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        check("unmapped", {7'h0, err}, 8'h01);
        wr(timer_ext_pkg::IDX_TL, 8'ha5);
        wr(timer_ext_pkg::IDX_TH, 8'h5a);
        rdc("low rw", timer_ext_pkg::IDX_TL, 8'ha5);
        rdc("high rw", timer_ext_pkg::IDX_TH, 8'h5a);
        wr(timer_ext_pkg::IDX_TL, 8'hfe);
        wr(timer_ext_pkg::IDX_TH, 8'h00);
        wr(timer_ext_pkg::IDX_CM, 8'h45);
        pulses(3);
        rdc("c16 low", timer_ext_pkg::IDX_TL, 8'h01);
        rdc("c16 high", timer_ext_pkg::IDX_TH, 8'h01);
        wr(timer_ext_pkg::IDX_CM, 8'h44);
        wr(timer_ext_pkg::IDX_TL, 8'h1f);
        wr(timer_ext_pkg::IDX_TH, 8'h00);
        pulses(1);
        rdc("c13 high", timer_ext_pkg::IDX_TH, 8'h01);
        wr(timer_ext_pkg::IDX_CM, 8'h4d);
        wr(timer_ext_pkg::IDX_TL, 8'h00);
        pulses(2);
        rdc("gated", timer_ext_pkg::IDX_TL, 8'h00);
        external_interrupt_three <= 1'b1;
        pulses(2);
        rdc("ungated", timer_ext_pkg::IDX_TL, 8'h02);
        wr(timer_ext_pkg::IDX_CM, 8'h46);
        wr(timer_ext_pkg::IDX_TH, 8'h10);
        wr(timer_ext_pkg::IDX_TL, 8'hfe);
        pulses(3);
        rdc("reload", timer_ext_pkg::IDX_TL, 8'h11);
        rdc("flag set", timer_ext_pkg::IDX_CM, 8'hc6);
        wr(timer_ext_pkg::IDX_CM, 8'h47);
        pulses(1);
        rdc("hold", timer_ext_pkg::IDX_TL, 8'h11);
        // Divide bits 00 give the 2x base, 01 the default base
        for (int t = 0; t < 4; t++)
        begin
            dv = (t[1] ? 12 : 6) / (t[0] ? 3 : 1);
            wr(timer_ext_pkg::IDX_PMR, 8'(t >> 1));
            wr(timer_ext_pkg::IDX_TL, 8'h00);
            wr(timer_ext_pkg::IDX_TH, 8'h00);
            wr(timer_ext_pkg::IDX_CM, t[0] ? 8'h61 : 8'h41);
            repeat (120) @(posedge mclk_i);
            wr(timer_ext_pkg::IDX_CM, 8'h01);
            apb(1'b0, timer_ext_pkg::IDX_TL, 8'h00);
            lo = 124 / dv;
            check("rate", 8'(rd >= lo - 1 && rd <= lo + 1), 8'h01);
        end
        // Reload every 64 clocks at the 4x divide-by-one base
        wr(timer_ext_pkg::IDX_PMR, 8'h04);
        wr(timer_ext_pkg::IDX_IEX, 8'h02);
        smode <= 2'h1;
        wr(timer_ext_pkg::IDX_TH, 8'hc0);
        wr(timer_ext_pkg::IDX_TL, 8'hc0);
        wr(timer_ext_pkg::IDX_CM, 8'h72);
        count_ticks(256);
        check("baud ticks", 8'(nb), 8'h04);
        check("irq", {7'h0, irq}, 8'h01);
        check("doubler", {7'h0, dbl}, 8'h01);
        check("vector", vec, 8'h4b);
        check("priority", {4'h0, pri}, 8'h09);
        smode <= 2'h2;
        count_ticks(256);
        check("baud off", 8'(nb), 8'h00);
        wr(timer_ext_pkg::IDX_CM, 8'h92);
        rdc("stopped", timer_ext_pkg::IDX_CM, 8'h92);
        ack <= 1'b1;
        @(posedge mclk_i);
        ack <= 1'b0;
        @(posedge mclk_i);
        rdc("flag clear", timer_ext_pkg::IDX_CM, 8'h12);
        check("irq clear", {7'h0, irq}, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            cfg = k ? 8'h02 : 8'h03;
            t2baud <= cfg[0];
            wr(timer_ext_pkg::IDX_D13, cfg);
            count_ticks(130);
            check("t1", 8'(n1), cfg[0] ? 8'h0a : 8'h00);
            check("t2", 8'(n2), cfg[0] ? 8'h00 : 8'h0a);
        end
        latch <= 1'b1;
        x32_en <= 1'b1;
        wr(timer_ext_pkg::IDX_COR, 8'h01);
        rdc("locked", timer_ext_pkg::IDX_COR, 8'h00);
        check("pin latch", {7'h0, pin}, 8'h01);
        for (int d = 0; d < 4; d++)
        begin
            unlock();
            wr(timer_ext_pkg::IDX_COR, {5'h00, 2'(d), 1'b1});
            halves();
            check("clk high", 8'(hi), 8'(d + 1));
            check("clk low", 8'(lo), 8'(d + 1));
        end
        unlock();
        wr(timer_ext_pkg::IDX_COR, 8'h81);
        rdc("x16 cfg", timer_ext_pkg::IDX_COR, 8'h81);
        halves();
        check("x16 high", 8'(hi), 8'h05);
        check("x16 low", 8'(lo), 8'h05);
        latch <= 1'b0;
        repeat (3) @(posedge mclk_i);
        check("pin gated", {7'h0, pin}, 8'h00);
        finish_test();
    end
endmodule
